//--- testbench.sv
// Self-checking testbench for the table-pointer flash access block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tpn_pkg::*;
    logic        clk_in, nrst_in, abort, rd, wt, prot, den, frd, fwr, fer, ack, ce;
    logic        st, err, done, irq, stall;
    logic [10:0] we;
    logic [7:0]  wd, lat, fdat;
    logic [21:0] awd, fad, ptr, last;
    logic [1:0]  md, dly;
    logic [15:0] frdata;
    logic [9:0]  wcnt;
    int          fail_count, tests_run;
    tpn_access tpn_access_i (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce),
        .reset_abort_in(abort), .ptr_upper_we_in(we[0]), .ptr_high_we_in(we[1]),
        .ptr_low_we_in(we[2]), .latch_we_in(we[3]), .addr_we_in(we[4]), .data_we_in(we[5]),
        .cmd_we_in(we[6]), .unlock_we_in(we[7]), .start_we_in(we[8]), .err_clr_in(we[9]),
        .done_clr_in(we[10]), .done_enable_in(den), .wdata_in(wd), .addr_wdata_in(awd),
        .tbl_rd_in(rd), .tbl_wt_in(wt), .tbl_mod_in(md), .fl_rd_out(frd), .fl_wr_out(fwr),
        .fl_erase_out(fer), .fl_addr_out(fad), .fl_wdata_out(), .fl_rdata_in(frdata),
        .fl_ack_in(ack), .fl_protect_in(prot), .byte_pointer_out(ptr), .byte_latch_out(lat),
        .flash_data_out(fdat), .start_out(st), .write_error_flag_out(err),
        .flash_done_flag_out(done), .irq_out(irq), .stall_out(stall));
    tpn_flash_model tpn_flash_model_i (.clk_in(clk_in), .nrst_in(nrst_in), .rd_in(frd),
        .wr_in(fwr), .erase_in(fer), .addr_in(fad), .delay_in(dly), .rdata_out(frdata),
        .ack_out(ack), .wr_count_out(wcnt), .last_addr_out(last));
    // ==========================================
    // Expectation helpers
    function automatic logic [21:0] step(logic [21:0] p, logic up);
        return {p[21], up ? p[20:0] + 21'h1 : p[20:0] - 21'h1};
    endfunction : step
    function automatic logic [7:0] byte_of(logic [21:0] p);
        return p[0] ? p[16:9] ^ 8'hC3 : p[8:1] ^ 8'h5A;
    endfunction : byte_of
    // ==========================================
    // Driver and compare tasks
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic idle(int n);
        repeat (n) @(negedge clk_in);
    endtask : idle
    task automatic reg_wr(int idx, logic [21:0] v);
        @(negedge clk_in);
        we[idx] = 1'b1;
        wd = v[7:0];
        awd = v;
        @(negedge clk_in);
        we = '0;
    endtask : reg_wr
    task automatic set_ptr(logic [21:0] p);
        reg_wr(0, 22'(p[21:16]));
        reg_wr(1, 22'(p[15:8]));
        reg_wr(2, 22'(p[7:0]));
        idle(2);
    endtask : set_ptr
    task automatic tbl(logic is_rd, logic [1:0] m);
        @(negedge clk_in);
        rd = is_rd;
        wt = !is_rd;
        md = m;
        @(negedge clk_in);
        rd = 1'b0;
        wt = 1'b0;
        idle(4);
    endtask : tbl
    task automatic go(logic [2:0] cmd, logic lock);
        reg_wr(6, 22'(cmd));
        if (lock) begin
            reg_wr(7, 22'(UNLOCK_1));
            reg_wr(7, 22'(UNLOCK_2));
        end
        reg_wr(8, 22'h00_0001);
    endtask : go
    task automatic wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            @(negedge clk_in);
            n++;
        end
        check("done flag", done, 1'b1);
        check("start bit", st, 1'b0);
    endtask : wait_done
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // ==========================================
    // Clock and watchdog
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        fail_count++;
        summarize();
    end
    // ==========================================
    // Main sequence
    initial begin
        logic [21:0] p, a, q;
        logic [1:0]  m;
        logic [9:0]  c;
        void'($urandom(32'hbdd1));
        {abort, rd, wt, prot, md, dly, wd, awd, we} = '0;
        den = 1'b1;
        ce = 1'b1;
        nrst_in = 1'b0;
        fail_count = 0;
        tests_run = 0;
        idle(2);
        nrst_in = 1'b1;
        idle(1);
        check("pointer reset", ptr, 22'h00_0000);
        for (int i = 0; i < 20; i++) begin
            p = 22'($urandom());
            m = 2'(i % 4);
            if (i == 17) p = 22'h3F_FFFF;
            if (i == 18) p = 22'h20_0000;
            if (i == 19) p = 22'h1F_FFFF;
            set_ptr(p);
            check("pointer", ptr, p);
            dly = 2'($urandom());
            tbl(1'b1, m);
            a = (m == 2'd3) ? step(p, 1'b1) : p;
            q = (m == 2'd0) ? p : step(p, m != 2'd2);
            check("latch", lat, byte_of(a));
            check("pointer step", ptr, q);
        end
        set_ptr(22'h01_23FF);
        reg_wr(3, 22'h00_00A7);
        idle(1);
        check("latch write", lat, 8'hA7);
        tbl(1'b0, 2'd1);
        check("pointer after write", ptr, 22'h01_2400);
        c = wcnt;
        reg_wr(4, 22'h01_2345);
        go(CMD_PAGE_WRITE, 1'b1);
        wait_done();
        check("write count", wcnt - c, 10'd256);
        check("page", last[21:8], 14'h0123);
        check("irq", irq, 1'b1);
        reg_wr(10, 22'h00_0000);
        go(CMD_PAGE_ERASE, 1'b1);
        wait_done();
        reg_wr(10, 22'h00_0000);
        den = 1'b0;
        go(CMD_PAGE_READ, 1'b0);
        wait_done();
        check("irq masked", irq, 1'b0);
        reg_wr(10, 22'h00_0000);
        reg_wr(4, 22'h30_00A4);
        go(CMD_BYTE_READ, 1'b0);
        wait_done();
        check("byte read", fdat, byte_of(22'h30_00A4));
        reg_wr(10, 22'h00_0000);
        den = 1'b1;
        go(CMD_PAGE_WRITE, 1'b0);
        idle(3);
        check("start no unlock", st, 1'b0);
        reg_wr(7, 22'(UNLOCK_1));
        reg_wr(5, 22'h00_0033);
        reg_wr(7, 22'(UNLOCK_2));
        reg_wr(8, 22'h00_0001);
        idle(3);
        check("start broken unlock", st, 1'b0);
        prot = 1'b1;
        go(CMD_PAGE_WRITE, 1'b1);
        idle(3);
        check("protect error", err, 1'b1);
        check("protect start", st, 1'b0);
        prot = 1'b0;
        reg_wr(9, 22'h00_0000);
        idle(1);
        check("error clear", err, 1'b0);
        reg_wr(4, ID_BASE);
        go(CMD_BYTE_WRITE, 1'b1);
        idle(3);
        check("id write error", err, 1'b1);
        reg_wr(9, 22'h00_0000);
        reg_wr(4, 22'h00_4000);
        dly = 2'd3;
        go(CMD_PAGE_WRITE, 1'b1);
        idle(20);
        abort = 1'b1;
        idle(1);
        abort = 1'b0;
        idle(3);
        check("abort error", err, 1'b1);
        nrst_in = 1'b0;
        idle(2);
        nrst_in = 1'b1;
        idle(2);
        check("error after reset", err, 1'b0);
        ce = 1'b0;
        reg_wr(2, 22'h00_005A);
        ce = 1'b1;
        idle(2);
        check("clock enable", ptr, 22'h00_0000);
        summarize();
    end
endmodule : testbench
bind tpn_access tpn_access_props tpn_access_props_i (.clk_in(clk_in), .nrst_in(nrst_in),
    .ce_in(ce_in), .tbl_rd_in(tbl_rd_in), .latch_we_in(latch_we_in), .start_we_in(start_we_in),
    .ptr_upper_we_in(ptr_upper_we_in), .fl_rd_out(fl_rd_out), .fl_wr_out(fl_wr_out),
    .fl_erase_out(fl_erase_out), .byte_pointer_out(byte_pointer_out),
    .byte_latch_out(byte_latch_out), .start_out(start_out),
    .flash_done_flag_out(flash_done_flag_out), .irq_out(irq_out), .stall_out(stall_out));
`default_nettype wire

//--- tpn_access.sv
// Table pointer and page-buffer flash access logic
`timescale 1ns/1ps
`default_nettype none
module tpn_access
    import tpn_pkg::*;
#(
    parameter int FLASH_LAT = 2
) (
    // Clock, reset, enable
    input  wire logic               clk_in,
    input  wire logic               nrst_in,
    input  wire logic               ce_in,
    input  wire logic               reset_abort_in,
    // Core register writes
    input  wire logic               ptr_upper_we_in,
    input  wire logic               ptr_high_we_in,
    input  wire logic               ptr_low_we_in,
    input  wire logic               latch_we_in,
    input  wire logic               addr_we_in,
    input  wire logic               data_we_in,
    input  wire logic               cmd_we_in,
    input  wire logic               unlock_we_in,
    input  wire logic               start_we_in,
    input  wire logic               err_clr_in,
    input  wire logic               done_clr_in,
    input  wire logic               done_enable_in,
    input  wire logic [7:0]         wdata_in,
    input  wire logic [FADDR_W-1:0] addr_wdata_in,
    // Table instructions
    input  wire logic               tbl_rd_in,
    input  wire logic               tbl_wt_in,
    input  wire logic [1:0]         tbl_mod_in,
    // Flash array port
    output logic                    fl_rd_out,
    output logic                    fl_wr_out,
    output logic                    fl_erase_out,
    output logic [FADDR_W-1:0]      fl_addr_out,
    output logic [WORD_W-1:0]       fl_wdata_out,
    input  wire logic [WORD_W-1:0]  fl_rdata_in,
    input  wire logic               fl_ack_in,
    input  wire logic               fl_protect_in,
    // Status
    output logic [PTR_W-1:0]        byte_pointer_out,
    output logic [7:0]              byte_latch_out,
    output logic [7:0]              flash_data_out,
    output logic                    start_out,
    output logic                    write_error_flag_out,
    output logic                    flash_done_flag_out,
    output logic                    irq_out,
    output logic                    stall_out
);
    // ==================================================
    // Helpers
    function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p, input logic dn);
        logic [20:0] lo;
        lo = dn ? p[20:0] - 21'd1 : p[20:0] + 21'd1;
        return {p[21], lo};
    endfunction : step

    function automatic logic in_rng(input logic [FADDR_W-1:0] a,
                                    input logic [FADDR_W-1:0] b,
                                    input logic [FADDR_W-1:0] e);
        return (a >= b) && (a <= e);
    endfunction : in_rng

    // ==================================================
    // Registers
    logic [PTR_W-1:0]   ptr_q;
    logic [7:0]         latch_q;
    logic [FADDR_W-1:0] addr_q;
    logic [7:0]         data_q;
    logic [2:0]         cmd_q;
    logic [1:0]         unlock_q;
    logic               start_q, err_q, done_q, ie_q;
    tpn_state_type      state_q;
    logic [7:0]         cfg_old_q;
    logic [BUF_AW-1:0]  idx_q;
    logic               page_hi_q;
    logic               rd_busy_q;
    logic [7:0]         rd_byte;

    // ==================================================
    // Operation decode
    logic        is_write_cmd, addr_bad, armed, go_req;
    logic [PTR_W-1:0] ptr_eff;
    assign is_write_cmd = (cmd_q == CMD_BYTE_WRITE) || (cmd_q == CMD_PAGE_WRITE)
                       || (cmd_q == CMD_PAGE_ERASE);
    assign addr_bad = is_write_cmd && (fl_protect_in || addr_q >= ID_BASE
                   || (addr_q[21] && !in_rng(addr_q, CFG_BASE, CFG_END)
                                  && !in_rng(addr_q, UID_BASE, UID_END)));
    assign armed  = (unlock_q == 2'd2);
    assign go_req = start_we_in && wdata_in[0] && !start_q;
    assign ptr_eff = (tbl_mod_in == TPN_MOD_PREINC) ? step(ptr_q, 1'b0) : ptr_q;

    // ==================================================
    // Pointer registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ptr_q <= '0;
        end else if (ce_in) begin
            if (ptr_upper_we_in) ptr_q[21:16] <= wdata_in[5:0];
            if (ptr_high_we_in)  ptr_q[15:8]  <= wdata_in;
            if (ptr_low_we_in)   ptr_q[7:0]   <= wdata_in;
            if ((tbl_rd_in && !rd_busy_q) || tbl_wt_in) begin
                unique case (tpn_mod_type'(tbl_mod_in))
                    TPN_MOD_NONE:    ptr_q <= ptr_q;
                    TPN_MOD_POSTINC: ptr_q <= step(ptr_q, 1'b0);
                    TPN_MOD_POSTDEC: ptr_q <= step(ptr_q, 1'b1);
                    TPN_MOD_PREINC:  ptr_q <= step(ptr_q, 1'b0);
                endcase
            end
        end
    end

    // ==================================================
    // Table read: one stall cycle, then latch loads
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_busy_q <= 1'b0;
        end else if (ce_in) begin
            rd_busy_q <= tbl_rd_in && !rd_busy_q;
        end
    end
    assign rd_byte = (state_q == TPN_RUN ? idx_q[0] : page_hi_q) ? fl_rdata_in[15:8]
                   : fl_rdata_in[7:0];

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            latch_q <= RST_BYTE;
            page_hi_q <= 1'b0;
        end else if (ce_in) begin
            if (tbl_rd_in && !rd_busy_q) page_hi_q <= ptr_eff[0];
            if (latch_we_in) latch_q <= wdata_in;
            else if (rd_busy_q) latch_q <= rd_byte;
        end
    end

    // ==================================================
    // Page buffer
    logic             b_we;
    logic [BUF_AW-1:0] b_wa, b_ra;
    logic [7:0]       b_wd, b_rd;
    assign b_we = tbl_wt_in || (state_q == TPN_RUN && cmd_q == CMD_PAGE_READ && fl_ack_in);
    assign b_wa = tbl_wt_in ? ptr_eff[BUF_AW-1:0] : idx_q;
    assign b_wd = tbl_wt_in ? latch_q : rd_byte;
    assign b_ra = idx_q;

    tpn_buf_ram #(.AW(BUF_AW), .DW(8)) u_buf (
        .clk_in    (clk_in),
        .en_in     (ce_in),
        .we_in     (b_we),
        .waddr_in  (b_wa),
        .wdata_in  (b_wd),
        .raddr_in  (b_ra),
        .rdata_out (b_rd)
    );

    // ==================================================
    // Control registers and unlock tracking
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr_q <= '0;
            cmd_q  <= RST_CMD;
            ie_q   <= 1'b0;
            unlock_q <= 2'd0;
        end else if (ce_in) begin
            if (!start_q) begin
                if (addr_we_in) addr_q <= addr_wdata_in;
                if (cmd_we_in)  cmd_q  <= wdata_in[2:0];
            end
            ie_q <= done_enable_in;
            if (unlock_we_in && wdata_in == UNLOCK_1) unlock_q <= 2'd1;
            else if (unlock_we_in && wdata_in == UNLOCK_2 && unlock_q == 2'd1) unlock_q <= 2'd2;
            else if (unlock_we_in || addr_we_in || cmd_we_in || data_we_in || start_we_in
                     || latch_we_in) unlock_q <= 2'd0;
        end
    end

    // ==================================================
    // Operation sequencer
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= TPN_IDLE;
            start_q <= 1'b0;
            idx_q   <= '0;
        end else if (ce_in) begin
            unique case (state_q)
                TPN_IDLE: begin
                    if (go_req && (!is_write_cmd || armed) && !addr_bad) begin
                        start_q <= 1'b1;
                        state_q <= TPN_RUN;
                        idx_q   <= '0;
                    end
                end
                TPN_RUN: begin
                    if (reset_abort_in) begin
                        state_q <= TPN_IDLE;
                        start_q <= 1'b0;
                    end else if (fl_ack_in) begin
                        if ((cmd_q == CMD_PAGE_READ || cmd_q == CMD_PAGE_WRITE)
                            && idx_q != 8'hFF) begin
                            idx_q <= idx_q + 8'd1;
                        end else begin
                            state_q <= TPN_DONE;
                        end
                    end
                end
                TPN_DONE: begin
                    start_q <= 1'b0;
                    state_q <= TPN_IDLE;
                end
                default: state_q <= TPN_IDLE;
            endcase
        end
    end

    // ==================================================
    // Data register, config protection merge
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_q <= RST_BYTE;
            cfg_old_q <= ~RST_BYTE;
        end else if (ce_in) begin
            if (data_we_in && !start_q) data_q <= wdata_in;
            else if (state_q == TPN_RUN && fl_ack_in && cmd_q == CMD_BYTE_READ)
                data_q <= addr_q[0] ? fl_rdata_in[15:8] : fl_rdata_in[7:0];
            if (state_q == TPN_RUN && fl_ack_in && cmd_q == CMD_BYTE_READ)
                cfg_old_q <= addr_q[0] ? fl_rdata_in[15:8] : fl_rdata_in[7:0];
        end
    end

    // Protection bit 0 (CP_MASK) is active low: written value may only clear it
    logic [7:0] cfg_val;
    logic       cfg_tgt;
    assign cfg_tgt = in_rng(addr_q, CFG_BASE, CFG_END);
    assign cfg_val = cfg_tgt ? (data_q & ~(CP_MASK & ~cfg_old_q)) : data_q;

    // ==================================================
    // Flags
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            err_q  <= 1'b0;
            done_q <= 1'b0;
        end else if (ce_in) begin
            if ((state_q == TPN_RUN && reset_abort_in && is_write_cmd)
                || (go_req && addr_bad && state_q == TPN_IDLE)) err_q <= 1'b1;
            else if (err_clr_in) err_q <= 1'b0;
            if (state_q == TPN_DONE) done_q <= 1'b1;
            else if (done_clr_in) done_q <= 1'b0;
        end
    end

    // ==================================================
    // Registered outputs
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fl_rd_out <= 1'b0;
            fl_wr_out <= 1'b0;
            fl_erase_out <= 1'b0;
            fl_addr_out <= '0;
            fl_wdata_out <= '0;
            irq_out <= 1'b0;
        end else if (ce_in) begin
            fl_rd_out <= (state_q == TPN_RUN && (cmd_q == CMD_BYTE_READ
                          || cmd_q == CMD_PAGE_READ)) || (tbl_rd_in && !rd_busy_q);
            fl_erase_out <= state_q == TPN_RUN && (cmd_q == CMD_PAGE_ERASE
                            || (cmd_q == CMD_BYTE_WRITE && cfg_tgt));
            fl_wr_out <= state_q == TPN_RUN && (cmd_q == CMD_PAGE_WRITE
                         || cmd_q == CMD_BYTE_WRITE);
            if (tbl_rd_in && !rd_busy_q) fl_addr_out <= ptr_eff;
            else if (cmd_q == CMD_PAGE_WRITE || cmd_q == CMD_PAGE_READ)
                fl_addr_out <= {addr_q[FADDR_W-1:BUF_AW], idx_q};
            else fl_addr_out <= addr_q;
            fl_wdata_out <= (cmd_q == CMD_PAGE_WRITE) ? {8'h00, b_rd} : {8'h00, cfg_val};
            irq_out <= done_q && ie_q;
        end
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            byte_pointer_out <= '0;
            byte_latch_out <= RST_BYTE;
            flash_data_out <= RST_BYTE;
            start_out <= 1'b0;
            write_error_flag_out <= 1'b0;
            flash_done_flag_out <= 1'b0;
            stall_out <= 1'b0;
        end else if (ce_in) begin
            byte_pointer_out <= ptr_q;
            byte_latch_out <= latch_q;
            flash_data_out <= data_q;
            start_out <= start_q;
            write_error_flag_out <= err_q;
            flash_done_flag_out <= done_q;
            stall_out <= tbl_rd_in && !rd_busy_q;
        end
    end
endmodule : tpn_access
`default_nettype wire

//--- tpn_access_props.sv
// Port-level checker for the table-pointer flash access block
`timescale 1ns/1ps
`default_nettype none
module tpn_access_props
    import tpn_pkg::*;
(
    // Clock and reset
    input wire logic             clk_in,
    input wire logic             nrst_in,
    // Watched inputs
    input wire logic             ce_in,
    input wire logic             tbl_rd_in,
    input wire logic             latch_we_in,
    input wire logic             start_we_in,
    input wire logic             ptr_upper_we_in,
    // Watched outputs
    input wire logic             fl_rd_out,
    input wire logic             fl_wr_out,
    input wire logic             fl_erase_out,
    input wire logic [PTR_W-1:0] byte_pointer_out,
    input wire logic [7:0]       byte_latch_out,
    input wire logic             start_out,
    input wire logic             flash_done_flag_out,
    input wire logic             irq_out,
    input wire logic             stall_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // ==========================================
    // Read handshake steps
    sequence s_rd_req;
        tbl_rd_in && ce_in && !stall_out && !start_out;
    endsequence
    sequence s_rd_busy;
        fl_rd_out && stall_out;
    endsequence
    // ==========================================
    // Assertions
    a_read_issue: assert property (s_rd_req |=> s_rd_busy)
        else $error("read strobe or stall missing");
    a_stall_once: assert property (stall_out && !start_out |=> !stall_out)
        else $error("stall held too long");
    a_latch_cause: assert property ($changed(byte_latch_out) |->
        $past(latch_we_in, 2) || $past(tbl_rd_in, 3))
        else $error("latch changed without cause");
    a_start_cause: assert property ($rose(start_out) |-> $past(start_we_in, 2))
        else $error("start set without request");
    a_done_start: assert property ($rose(flash_done_flag_out) |-> $fell(start_out))
        else $error("done flag without start clear");
    a_irq_gate: assert property (irq_out |-> flash_done_flag_out)
        else $error("irq without done flag");
    a_ptr_bank: assert property ($changed(byte_pointer_out[21]) |->
        $past(ptr_upper_we_in, 2))
        else $error("pointer bit 21 moved");
    a_write_run: assert property (fl_wr_out |-> start_out)
        else $error("flash write outside operation");
    a_erase_run: assert property (fl_erase_out |-> start_out)
        else $error("flash erase outside operation");
endmodule : tpn_access_props
`default_nettype wire

//--- tpn_buf_ram.sv
// Page buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tpn_buf_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock
    input  wire logic          clk_in,
    input  wire logic          en_in,
    // Write port
    input  wire logic          we_in,
    input  wire logic [AW-1:0] waddr_in,
    input  wire logic [DW-1:0] wdata_in,
    // Read port
    input  wire logic [AW-1:0] raddr_in,
    output var  logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_in) begin
        if (en_in && we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        if (en_in) begin
            rdata_out <= mem[raddr_in];
        end
    end
endmodule : tpn_buf_ram
`default_nettype wire

//--- tpn_flash_model.sv
// Behavioural flash array on the far side of the access block
`timescale 1ns/1ps
`default_nettype none
module tpn_flash_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // Array port
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic        erase_in,
    input  wire logic [21:0] addr_in,
    input  wire logic [1:0]  delay_in,
    output logic      [15:0] rdata_out,
    output logic             ack_out,
    // Observation
    output logic      [9:0]  wr_count_out,
    output logic      [21:0] last_addr_out
);
    logic [1:0]  wait_q;
    logic [15:0] junk_q;
    // Word content is a fixed pattern of its word address
    assign rdata_out = rd_in ? {addr_in[16:9] ^ 8'hC3, addr_in[8:1] ^ 8'h5A} : junk_q;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_q <= 2'h0;
            ack_out <= 1'b0;
            junk_q <= 16'hA5A5;
        end else begin
            junk_q <= ~junk_q;
            if ((rd_in || wr_in || erase_in) && !ack_out) begin
                ack_out <= (wait_q == delay_in);
                wait_q <= (wait_q == delay_in) ? 2'h0 : wait_q + 2'h1;
            end else begin
                ack_out <= 1'b0;
            end
        end
    end
    // Count committed writes
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_count_out <= 10'h000;
            last_addr_out <= 22'h00_0000;
        end else if (wr_in && ack_out) begin
            wr_count_out <= wr_count_out + 10'h001;
            last_addr_out <= addr_in;
        end
    end
endmodule : tpn_flash_model
`default_nettype wire

//--- tpn_pkg.sv
// Package for table-pointer flash access block
package tpn_pkg;
    // ==================================================
    // Widths and sizes
    localparam int PTR_W      = 22;
    localparam int BUF_AW     = 8;
    localparam int BUF_DEPTH  = 256;
    localparam int WORD_W     = 16;
    localparam int FADDR_W    = 22;
    // ==================================================
    // Pointer modifiers
    typedef enum logic [1:0] {
        TPN_MOD_NONE = 2'b00,
        TPN_MOD_POSTINC = 2'b01,
        TPN_MOD_POSTDEC = 2'b10,
        TPN_MOD_PREINC = 2'b11
    } tpn_mod_type;
    // ==================================================
    // Flash command codes
    localparam logic [2:0] CMD_BYTE_READ  = 3'h0;
    localparam logic [2:0] CMD_PAGE_READ  = 3'h2;
    localparam logic [2:0] CMD_BYTE_WRITE = 3'h3;
    localparam logic [2:0] CMD_PAGE_WRITE = 3'h5;
    localparam logic [2:0] CMD_PAGE_ERASE = 3'h6;
    // ==================================================
    // Unlock bytes
    localparam logic [7:0] UNLOCK_1 = 8'h55;
    localparam logic [7:0] UNLOCK_2 = 8'hAA;
    // ==================================================
    // Address space map (bit 21 set selects info spaces)
    localparam logic [FADDR_W-1:0] CFG_BASE = 22'h30_0000;
    localparam logic [FADDR_W-1:0] CFG_END  = 22'h30_00FF;
    localparam logic [FADDR_W-1:0] UID_BASE = 22'h20_0000;
    localparam logic [FADDR_W-1:0] UID_END  = 22'h20_00FF;
    localparam logic [FADDR_W-1:0] ID_BASE  = 22'h3F_FFFC;
    localparam logic [7:0]         CP_MASK  = 8'h01;
    // ==================================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_CMD  = 3'h0;
    // ==================================================
    // States
    typedef enum logic [1:0] {
        TPN_IDLE = 2'b00,
        TPN_RUN  = 2'b01,
        TPN_DONE = 2'b11
    } tpn_state_type;
endpackage : tpn_pkg
